// *** hbd_diag_monitor.sv ***
// Purpose: Port checks on the H-bridge fault diagnostics block.
// Assumes: One clock domain, rst async high.
// Notes: Bound in from the testbench file.
`timescale 1ns/1ps
module hbd_diag_monitor #(
  parameter int unsigned OPEN_LOAD_LIMIT = hbd_pkg::OPEN_LOAD_CYCLES
) (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic dirCtrlA, // Dir A
  input wire logic dirCtrlB, // Dir B
  input wire logic overTemp, // Sense
  input wire logic underVoltage, // Sense
  input wire logic overVoltage, // Sense
  input wire logic openLoadSense, // Sense
  input wire logic shortAtoB, // Sense
  input wire logic shortAtoGnd, // Sense
  input wire logic shortBtoGnd, // Sense
  input wire logic shortAtoSupply, // Sense
  input wire logic shortBtoSupply, // Sense
  input wire logic [1:0] highConducting, // Monitor
  input wire logic [1:0] lowConducting, // Monitor
  input wire logic [1:0] highSideSwitch, // Gate
  input wire logic [1:0] lowSideSwitch, // Gate
  input wire logic faultPulseNOut, // Status
  input wire logic faultPulseNOe, // Status
  input wire logic faultLatchedN // Status
);
  import hbd_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] oeRun_ff;
  // Saturates so a stuck fault cannot wrap back under the limit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) oeRun_ff <= 8'h00;
    else if (!faultPulseNOe) oeRun_ff <= 8'h00;
    else if (oeRun_ff != 8'hff) oeRun_ff <= oeRun_ff + 8'h01;
  end
  sequence seqHeldLow;
    !faultLatchedN && $stable({dirCtrlA, dirCtrlB}) && !$past(rst);
  endsequence
  chk_half_a_excl: assert property (!(highSideSwitch[0] && lowSideSwitch[0])) else $error("half A shoot-through");
  chk_half_b_excl: assert property (!(highSideSwitch[1] && lowSideSwitch[1])) else $error("half B shoot-through");
  chk_monitor_block: assert property ((lowConducting[0] && !highSideSwitch[0]) |=> !highSideSwitch[0])
    else $error("high A on while low A conducts");
  chk_temp_gates_off: assert property (overTemp |=> {highSideSwitch, lowSideSwitch} == 4'h0) else $error("gates on in overtemp");
  chk_uv_gates_off: assert property (underVoltage |=> {highSideSwitch, lowSideSwitch} == 4'h0) else $error("gates on in uv");
  chk_ov_gates_off: assert property (overVoltage |=> {highSideSwitch, lowSideSwitch} == 4'h0) else $error("gates on in ov");
  chk_quiet_latched: assert property ({dirCtrlA, dirCtrlB} == 2'h0 |=> !faultLatchedN) else $error("latched high in quiescent");
  chk_high_a_mode: assert property (highSideSwitch[0] |-> $past(dirCtrlA)) else $error("high A on without dir A");
  chk_latch_holds: assert property (seqHeldLow |=> !faultLatchedN) else $error("latched status dropped without toggle");
  chk_pulse_min: assert property ($fell(faultPulseNOe) |-> oeRun_ff >= PULSE_MIN_CYCLES) else $error("pulse too short");
endmodule : hbd_diag_monitor

// *** hbd_fault_diag.sv ***
// Purpose: Drive decode, protection latches and status reporting for an H-bridge.
// Assumes: All sense inputs are digital comparator results synchronous to core_clk.
// Notes: Open-drain pulsed status is given as a value and an output enable.
`timescale 1ns/1ps

module hbd_fault_diag #(
  parameter int unsigned OPEN_LOAD_LIMIT = hbd_pkg::OPEN_LOAD_CYCLES
) (
  input wire logic core_clk, // Core clock, 50 MHz
  input wire logic rst, // Async reset, high
  input wire logic dirCtrlA, // Direction input A
  input wire logic dirCtrlB, // Direction input B
  input wire logic overTemp, // Junction over-temperature trip
  input wire logic underVoltage, // Supply at or below under-voltage threshold
  input wire logic overVoltage, // Supply at or above over-voltage threshold
  input wire logic openLoadSense, // Open-load current criterion met
  input wire logic shortAtoB, // Short between outputs
  input wire logic shortAtoGnd, // Output A shorted to ground
  input wire logic shortBtoGnd, // Output B shorted to ground
  input wire logic shortAtoSupply, // Output A shorted to supply
  input wire logic shortBtoSupply, // Output B shorted to supply
  input wire logic [1:0] highConducting, // High-side active monitor per half
  input wire logic [1:0] lowConducting, // Low-side active monitor per half
  output logic [1:0] highSideSwitch, // High-side gate per half
  output logic [1:0] lowSideSwitch, // Low-side gate per half
  output logic faultPulseNOut, // Pulsed status drive value
  output logic faultPulseNOe, // Pulsed status enable, high pulls low
  output logic faultLatchedN // Latched status, low on fault
);
  import hbd_pkg::*;

  localparam logic [PULSE_WIDTH-1:0] PULSE_LOAD = PULSE_WIDTH'(PULSE_MIN_CYCLES);

  function automatic hbd_mode_t dirToMode(input logic [1:0] dir);
    hbd_mode_t m;
    m = MODE_QUIESCENT;
    unique case (dir)
      2'h0: m = MODE_QUIESCENT;
      2'h1: m = MODE_CLOCKWISE;
      2'h2: m = MODE_COUNTER;
      2'h3: m = MODE_BRAKE;
    endcase
    return m;
  endfunction : dirToMode

  logic [1:0] dirNow;
  logic [1:0] dirPrev_ff;
  logic inputToggle;
  hbd_mode_t modeNow;
  logic isQuiescent;
  logic isDriving;

  assign dirNow = {dirCtrlA, dirCtrlB};
  assign modeNow = dirToMode(dirNow);
  assign isQuiescent = (modeNow == MODE_QUIESCENT);
  assign isDriving = (modeNow == MODE_CLOCKWISE) || (modeNow == MODE_COUNTER);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dirPrev_ff <= DIR_RST;
    end else begin
      dirPrev_ff <= dirNow;
    end
  end

  assign inputToggle = (dirNow != dirPrev_ff);

  // Short detection only counts when the input drives the shorted node
  logic ocRaw;
  always_comb begin
    ocRaw = 1'b0;
    unique case (modeNow)
      MODE_QUIESCENT: ocRaw = 1'b0;
      MODE_CLOCKWISE: ocRaw = shortAtoB || shortBtoGnd || shortAtoSupply;
      MODE_COUNTER: ocRaw = shortAtoB || shortAtoGnd || shortBtoSupply;
      MODE_BRAKE: ocRaw = shortAtoGnd || shortBtoGnd;
    endcase
  end

  hbd_tmr_if ocTmr ();
  hbd_tmr_if olTmr ();

  assign ocTmr.run = ocRaw;
  assign olTmr.run = openLoadSense;

  hbd_timer #(.LIMIT(OC_DELAY_CYCLES)) ocDeglitch (
    .core_clk(core_clk),
    .rst(rst),
    .tmr(ocTmr)
  );

  hbd_timer #(.LIMIT(OPEN_LOAD_LIMIT)) olQualify (
    .core_clk(core_clk),
    .rst(rst),
    .tmr(olTmr)
  );

  // Protection latches; a set in the clearing cycle wins
  logic ocLatched_ff;
  logic otLatched_ff;
  logic ovLatched_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ocLatched_ff <= 1'b0;
    end else begin
      ocLatched_ff <= ocTmr.expired || (ocLatched_ff && !inputToggle);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      otLatched_ff <= 1'b0;
    end else begin
      otLatched_ff <= overTemp || (otLatched_ff && !inputToggle);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovLatched_ff <= 1'b0;
    end else begin
      ovLatched_ff <= overVoltage || (ovLatched_ff && !inputToggle);
    end
  end

  // Live conditions also block, so the gates drop on the same edge that a latch sets
  logic driveEnable;
  assign driveEnable = !ocLatched_ff && !ocTmr.expired
    && !otLatched_ff && !overTemp
    && !ovLatched_ff && !overVoltage
    && !underVoltage;

  logic [1:0] wantHigh;
  logic [1:0] wantLow;
  always_comb begin
    wantHigh = 2'h0;
    wantLow = 2'h0;
    unique case (modeNow)
      MODE_QUIESCENT: begin
        wantHigh = 2'h0;
        wantLow = 2'h0;
      end
      MODE_CLOCKWISE: begin
        wantHigh[HALF_B] = 1'b1;
        wantLow[HALF_A] = 1'b1;
      end
      MODE_COUNTER: begin
        wantHigh[HALF_A] = 1'b1;
        wantLow[HALF_B] = 1'b1;
      end
      MODE_BRAKE: begin
        wantHigh = 2'h3;
        wantLow = 2'h0;
      end
    endcase
  end

  // Monitor of the opposite transistor holds a gate off until it has released
  genvar h;
  generate
    for (h = 0; h < 2; h++) begin : gHalf
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          highSideSwitch[h] <= GATE_RST[h];
          lowSideSwitch[h] <= GATE_RST[h];
        end else begin
          highSideSwitch[h] <= driveEnable && wantHigh[h] && !lowConducting[h] && !lowSideSwitch[h];
          lowSideSwitch[h] <= driveEnable && wantLow[h] && !highConducting[h] && !highSideSwitch[h];
        end
      end
    end
  endgenerate

  // Status: under-voltage and over-voltage take no part here
  // Latch next states, so a latch cleared by a toggle cannot re-arm the status latch
  logic olFault;
  logic ocActive;
  logic otActive;
  logic faultNow;
  assign olFault = olTmr.expired && isDriving;
  assign ocActive = ocTmr.expired || (ocLatched_ff && !inputToggle);
  assign otActive = overTemp || (otLatched_ff && !inputToggle);
  assign faultNow = ocActive
    || (otActive && !isQuiescent)
    || olFault;

  logic [PULSE_WIDTH-1:0] pulseCnt_ff;
  logic [PULSE_WIDTH-1:0] nxt_pulseCnt;
  always_comb begin
    nxt_pulseCnt = pulseCnt_ff;
    if (faultNow) begin
      nxt_pulseCnt = PULSE_LOAD;
    end else if (pulseCnt_ff != PULSE_RST) begin
      nxt_pulseCnt = pulseCnt_ff - 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pulseCnt_ff <= PULSE_RST;
    end else begin
      pulseCnt_ff <= nxt_pulseCnt;
    end
  end

  // Stretch counter keeps the pin low past the fault end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      faultPulseNOe <= 1'b0;
      faultPulseNOut <= 1'b0;
    end else begin
      faultPulseNOe <= faultNow || (pulseCnt_ff > 8'h01);
      faultPulseNOut <= 1'b0;
    end
  end

  logic statLatch_ff;
  logic nxt_statLatch;
  assign nxt_statLatch = faultNow || (statLatch_ff && !inputToggle);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      statLatch_ff <= 1'b0;
    end else begin
      statLatch_ff <= nxt_statLatch;
    end
  end

  // Quiescent pulls the latched pin low, as the bias pull-down would
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      faultLatchedN <= 1'b0;
    end else begin
      faultLatchedN <= !(nxt_statLatch || isQuiescent);
    end
  end

endmodule : hbd_fault_diag

// *** hbd_mcu_model.sv ***
// Purpose: Controller driving direction inputs, plus bridge transistor monitors.
// Assumes: Commands come from the bench on core_clk.
// Notes: Transistors follow their gates one cycle late.
`timescale 1ns/1ps
module hbd_mcu_model (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [1:0] modeCmd, // Wanted {A,B}
  input wire logic [1:0] highSideSwitch, // Gate
  input wire logic [1:0] lowSideSwitch, // Gate
  output logic dirCtrlA, // Dir A
  output logic dirCtrlB, // Dir B
  output logic [1:0] highConducting, // Monitor
  output logic [1:0] lowConducting // Monitor
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) {dirCtrlA, dirCtrlB} <= 2'h0;
    else if (modeCmd == 2'h0 && dirCtrlA != dirCtrlB) {dirCtrlA, dirCtrlB} <= 2'h3;
    else {dirCtrlA, dirCtrlB} <= modeCmd;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) {highConducting, lowConducting} <= 4'h0;
    else {highConducting, lowConducting} <= {highSideSwitch, lowSideSwitch};
  end
endmodule : hbd_mcu_model

// *** hbd_pkg.sv ***
// Purpose: Shared constants and types for the H-bridge fault diagnostics block.
// Assumes: Core clock of 50 MHz (20 ns period).
// Notes: Times are kept in ns; cycle counts are derived from them.
package hbd_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;

  // Over-current deglitch: nominal delay, rounded up to whole cycles
  localparam int unsigned OC_DELAY_NS = 10000;
  localparam int unsigned OC_DELAY_CYCLES = (OC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Open-load qualification: least time, rounded up
  localparam int unsigned OPEN_LOAD_NS = 1000000;
  localparam int unsigned OPEN_LOAD_CYCLES = (OPEN_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Pulsed status least low time, rounded up
  localparam int unsigned PULSE_MIN_NS = 3000;
  localparam int unsigned PULSE_MIN_CYCLES = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned TMR_WIDTH = 16;
  localparam int unsigned PULSE_WIDTH = 8;

  // Half-bridge index positions in the gate vectors
  localparam int unsigned HALF_A = 0;
  localparam int unsigned HALF_B = 1;

  // Reset values
  localparam logic [1:0] GATE_RST = 2'h0;
  localparam logic [1:0] DIR_RST = 2'h0;
  localparam logic [TMR_WIDTH-1:0] TMR_RST = 16'h0000;
  localparam logic [PULSE_WIDTH-1:0] PULSE_RST = 8'h00;

  typedef enum logic [1:0] {
    MODE_QUIESCENT,
    MODE_CLOCKWISE,
    MODE_COUNTER,
    MODE_BRAKE
  } hbd_mode_t;

endpackage : hbd_pkg

// *** hbd_testbench.sv ***
// Purpose: Self-checking bench for the fault diagnostics block.
// Assumes: 50 MHz clock, open-load limit shortened to 20.
// Notes: Each table row starts from a fresh reset.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [1:0] mode; logic [8:0] sense; logic [9:0] hold; logic [5:0] exp;} hbd_row_t;
  logic core_clk = 1'b0, rst = 1'b1, dirCtrlA, dirCtrlB, faultPulseNOut, faultPulseNOe, faultLatchedN;
  logic overTemp, underVoltage, overVoltage, openLoadSense, shortAtoB, shortAtoGnd, shortBtoGnd;
  logic shortAtoSupply, shortBtoSupply;
  logic [1:0] modeCmd = 2'h0, highConducting, lowConducting, highSideSwitch, lowSideSwitch;
  logic [8:0] sense = 9'h000;
  int mismatches = 0, total_checks = 0;
  // Exp is {high gates, low gates, pulse enable, latched status}
  hbd_row_t rows[21] = '{'{2'h1, 9'h000, 10'h005, 6'h25}, '{2'h2, 9'h000, 10'h005, 6'h19},
    '{2'h3, 9'h000, 10'h005, 6'h31}, '{2'h0, 9'h000, 10'h005, 6'h00}, '{2'h1, 9'h020, 10'h028, 6'h26},
    '{2'h2, 9'h020, 10'h028, 6'h1A}, '{2'h3, 9'h020, 10'h028, 6'h31}, '{2'h0, 9'h020, 10'h028, 6'h00},
    '{2'h1, 9'h010, 10'h208, 6'h02}, '{2'h2, 9'h010, 10'h208, 6'h02}, '{2'h2, 9'h008, 10'h208, 6'h02},
    '{2'h3, 9'h008, 10'h208, 6'h02}, '{2'h1, 9'h004, 10'h208, 6'h02}, '{2'h3, 9'h004, 10'h208, 6'h02},
    '{2'h1, 9'h002, 10'h208, 6'h02}, '{2'h2, 9'h001, 10'h208, 6'h02}, '{2'h2, 9'h002, 10'h208, 6'h19},
    '{2'h1, 9'h100, 10'h005, 6'h02}, '{2'h3, 9'h100, 10'h005, 6'h02}, '{2'h0, 9'h100, 10'h005, 6'h00},
    '{2'h1, 9'h006, 10'h005, 6'h25}};
  assign {overTemp, underVoltage, overVoltage, openLoadSense, shortAtoB} = sense[8:4];
  assign {shortAtoGnd, shortBtoGnd, shortAtoSupply, shortBtoSupply} = sense[3:0];
  always #10 core_clk = ~core_clk;
  hbd_fault_diag #(.OPEN_LOAD_LIMIT(20)) hbd_fault_diag_i (.core_clk, .rst, .dirCtrlA, .dirCtrlB, .overTemp,
    .underVoltage, .overVoltage, .openLoadSense, .shortAtoB, .shortAtoGnd, .shortBtoGnd, .shortAtoSupply,
    .shortBtoSupply, .highConducting, .lowConducting, .highSideSwitch, .lowSideSwitch, .faultPulseNOut,
    .faultPulseNOe, .faultLatchedN);
  hbd_mcu_model hbd_mcu_model_i (.core_clk, .rst, .modeCmd, .highSideSwitch, .lowSideSwitch, .dirCtrlA,
    .dirCtrlB, .highConducting, .lowConducting);
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask : step
  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic expect_out(input logic [5:0] exp);
    @(negedge core_clk);
    check({highSideSwitch, lowSideSwitch, faultPulseNOe, faultLatchedN}, exp);
    check({5'h00, faultPulseNOut}, 6'h00);
    @(posedge core_clk);
  endtask : expect_out
  task automatic reset_dut();
    rst <= 1'b1;
    modeCmd <= 2'h0;
    sense <= 9'h000;
    step(3);
    rst <= 1'b0;
  endtask : reset_dut
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // Covers decode, open load, each short, unlisted combos and overtemp
  initial begin
    foreach (rows[i]) begin
      reset_dut();
      modeCmd <= rows[i].mode;
      sense <= rows[i].sense;
      step(rows[i].hold);
      expect_out(rows[i].exp);
    end
    $display("table done");
    reset_dut();
    modeCmd <= 2'h1;
    sense <= 9'h004;
    step(480);
    expect_out(6'h25);
    step(40);
    expect_out(6'h02);
    sense <= 9'h000;
    step(100);
    expect_out(6'h02);
    modeCmd <= 2'h2;
    step(5);
    expect_out(6'h1B);
    step(160);
    expect_out(6'h19);
    $display("overcurrent latch done");
    reset_dut();
    modeCmd <= 2'h3;
    step(5);
    sense <= 9'h080;
    step(5);
    expect_out(6'h01);
    sense <= 9'h000;
    step(5);
    expect_out(6'h31);
    sense <= 9'h040;
    step(5);
    sense <= 9'h000;
    step(5);
    expect_out(6'h01);
    modeCmd <= 2'h2;
    step(5);
    expect_out(6'h19);
    $display("supply faults done");
    sense <= 9'h100;
    step(2);
    sense <= 9'h000;
    step(5);
    expect_out(6'h02);
    modeCmd <= 2'h1;
    step(5);
    expect_out(6'h27);
    $display("overtemp latch done");
    // Direct reversal: monitors must hold the new gates off for a cycle
    modeCmd <= 2'h2;
    step(3);
    expect_out(6'h03);
    step(1);
    expect_out(6'h1B);
    modeCmd <= 2'h0;
    step(2);
    expect_out(6'h13);
    expect_out(6'h02);
    $display("interlock done");
    close_out();
  end
  initial begin
    // Roughly two and a half times the expected run length
    #300_000;
    mismatches++;
    close_out();
  end
endmodule : testbench
bind hbd_fault_diag hbd_diag_monitor #(.OPEN_LOAD_LIMIT(OPEN_LOAD_LIMIT)) hbd_diag_monitor_i (.core_clk, .rst,
  .dirCtrlA, .dirCtrlB, .overTemp, .underVoltage, .overVoltage, .openLoadSense, .shortAtoB, .shortAtoGnd,
  .shortBtoGnd, .shortAtoSupply, .shortBtoSupply, .highConducting, .lowConducting, .highSideSwitch,
  .lowSideSwitch, .faultPulseNOut, .faultPulseNOe, .faultLatchedN);

// *** hbd_timer.sv ***
// Purpose: Counts consecutive cycles of a level and flags when a limit is reached.
// Assumes: run is synchronous to core_clk.
// Notes: Any drop of run restarts the count, which gives the deglitch behaviour.
`timescale 1ns/1ps
module hbd_timer #(
  parameter int unsigned LIMIT = 1
) (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Async reset, high
  hbd_tmr_if.timer tmr // Run level in, expiry out
);
  import hbd_pkg::*;

  localparam logic [TMR_WIDTH-1:0] LIMIT_W = TMR_WIDTH'(LIMIT);

  logic [TMR_WIDTH-1:0] count_ff;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_ff <= TMR_RST;
    end else if (!tmr.run) begin
      count_ff <= TMR_RST;
    end else if (count_ff != LIMIT_W) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  // Saturates, so expiry holds as long as the condition does
  assign tmr.expired = tmr.run && (count_ff == LIMIT_W);

endmodule : hbd_timer

// *** hbd_tmr_if.sv ***
// Purpose: Carrier between the diagnostics core and its qualification timers.
// Assumes: Both ends share core_clk.
// Notes: run is a level; expired stays high while run holds past the limit.
`timescale 1ns/1ps
interface hbd_tmr_if;
  logic run;
  logic expired;
  modport owner (output run, input expired);
  modport timer (input run, output expired);
endinterface : hbd_tmr_if
